// ### rtl/iec_pkg.sv
// Purpose: shared constants and carriers for the event clear register bank
// Assumes: 32-bit AHB-Lite data, word-aligned registers
// Notes:   byte offsets are the low address bits decoded by the slave

package iec_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_ABORT_CLR = 8'h54;
   localparam logic [7:0] OFS_RXDONE_CLR = 8'h58;
   localparam logic [7:0] OFS_ACT_CLR = 8'h5C;
   localparam logic [7:0] OFS_STOP_CLR = 8'h60;
   localparam logic [7:0] OFS_INT_STAT = 8'h80;
   localparam logic [7:0] OFS_INT_EN = 8'h84;
   localparam logic [7:0] OFS_INT_CLR = 8'h88;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned POS_ABORT = 6;
   localparam int unsigned POS_RXDONE = 7;
   localparam int unsigned POS_ACT = 8;
   localparam int unsigned POS_STOP = 9;
   localparam int unsigned POS_CAUSE_KEEP = 9;
   localparam int unsigned IRQ_ABORT = 0;
   localparam int unsigned IRQ_RXDONE = 1;
   localparam int unsigned IRQ_ACT = 2;
   localparam int unsigned IRQ_STOP = 3;
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned CAUSE_W = 32;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] RST_INT_EN = 4'h0;
   localparam logic [CAUSE_W-1:0] RST_CAUSE = 32'h0000_0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   // read request, valid in the address phase
   typedef struct packed
   {
      logic valid;
      logic [ADDR_W-1:0] addr;
   } iec_rd_s;

   // write request, valid in the data phase
   typedef struct packed
   {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [31:0] data;
   } iec_wr_s;

   // event and state inputs from the controller
   typedef struct packed
   {
      logic abort_set;
      logic rx_done_set;
      logic stop_set;
      logic ctrl_active;
      logic ctrl_enabled;
   } iec_evt_s;

endpackage : iec_pkg

// ### rtl/iec_sticky.sv
// Purpose: bank of sticky flags, set by hardware and cleared by software
// Assumes: set and clear are one-cycle vectors in the core_clk domain
// Notes:   a set in the cycle of its clear wins

`timescale 1ns/1ps

module iec_sticky #(
   parameter int unsigned W = 4
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // set and clear vectors
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   // registered flags
   output logic [W-1:0] flags
);
   import iec_pkg::*;

   typedef struct packed
   {
      logic [W-1:0] flags;
   } iec_stk_s;

   iec_stk_s state;
   iec_stk_s next_state;

   // per-bit next value, set over clear
   always_comb
   begin
      next_state = state;
      for (int i = 0; i < W; i++)
      begin
         next_state.flags[i] = set[i] | (state.flags[i] & ~clr[i]);
      end
   end

   // state register
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign flags = state.flags;

endmodule : iec_sticky

// ### rtl/iec_ahb_slave.sv
// Purpose: AHB-Lite front end, turns bus phases into read and write strobes
// Assumes: single word transfers, zero wait states
// Notes:   reads act in the address phase, writes in the data phase

`timescale 1ns/1ps

module iec_ahb_slave (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // ahb address phase
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   // ahb data phase
   input wire logic [31:0] hwdata,
   // strobes to the register bank
   output iec_pkg::iec_rd_s rd,
   output iec_pkg::iec_wr_s wr
);
   import iec_pkg::*;

   typedef struct packed
   {
      logic wr_pend;
      logic [ADDR_W-1:0] wr_addr;
   } iec_slv_s;

   iec_slv_s state;
   iec_slv_s next_state;
   logic take;

   // a transfer is taken on nonseq or seq with the bus ready
   assign take = hsel & htrans[1] & hready;

   // read strobe straight from the address phase
   always_comb
   begin
      rd.valid = take & ~hwrite;
      rd.addr = haddr[ADDR_W-1:0];
      wr.valid = state.wr_pend;
      wr.addr = state.wr_addr;
      wr.data = hwdata;
   end

   // remember a write address until its data phase
   always_comb
   begin
      next_state = state;
      if (hready)
      begin
         next_state.wr_pend = take & hwrite;
         next_state.wr_addr = haddr[ADDR_W-1:0];
      end
   end

   // state register
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

endmodule : iec_ahb_slave

// ### rtl/iec_regs.sv
// Purpose: read-to-clear event registers of a two-wire bus controller
// Assumes: AHB-Lite slave on core_clk, controller events synchronous
// Notes:   owns the raw event flags, abort cause and tx fifo flush state
//
// The implementer's own choice: the AHB-Lite slave port.

`timescale 1ns/1ps

module iec_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // controller events and state
   input wire iec_pkg::iec_evt_s evt,
   input wire logic [iec_pkg::CAUSE_W-1:0] abort_cause_set,
   input wire logic abort_keep_hold,
   // register contents towards the controller
   output logic [31:0] raw_event_status,
   output logic [iec_pkg::CAUSE_W-1:0] abort_cause_register,
   output logic tx_fifo_flushed,
   // interrupt
   output logic irq
);
   import iec_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic transmit_abort_flag;
      logic rx_done_flag;
      logic act_flag;
      logic stop_seen_flag;
      logic [CAUSE_W-1:0] cause;
      logic flushed;
      logic [IRQ_W-1:0] int_en;
      logic [31:0] rdata;
      logic irq;
      logic ready;
   } iec_top_s;

   iec_top_s state;
   iec_top_s next_state;

   iec_rd_s rd;
   iec_wr_s wr;
   logic [IRQ_W-1:0] int_set;
   logic [IRQ_W-1:0] int_clr;
   logic [IRQ_W-1:0] int_stat;
   logic rd_abort;
   logic rd_rxdone;
   logic rd_act;
   logic rd_stop;
   logic [CAUSE_W-1:0] cause_clr;

   // address match, used for reads and writes alike
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   iec_ahb_slave u_slave (
      .core_clk (core_clk),
      .rst_n (rst_n),
      .hsel (hsel),
      .haddr (haddr),
      .htrans (htrans),
      .hwrite (hwrite),
      .hready (hready),
      .hwdata (hwdata),
      .rd (rd),
      .wr (wr)
   );

   // read strobes for the four clear registers
   always_comb
   begin
      rd_abort = rd.valid & hit(rd.addr, OFS_ABORT_CLR);
      rd_rxdone = rd.valid & hit(rd.addr, OFS_RXDONE_CLR);
      rd_act = rd.valid & hit(rd.addr, OFS_ACT_CLR);
      rd_stop = rd.valid & hit(rd.addr, OFS_STOP_CLR);
   end

   // ----------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------
   // events that enter the sticky status
   always_comb
   begin
      int_set = '0;
      int_set[IRQ_ABORT] = evt.abort_set;
      int_set[IRQ_RXDONE] = evt.rx_done_set;
      int_set[IRQ_ACT] = evt.ctrl_active & ~state.act_flag;
      int_set[IRQ_STOP] = evt.stop_set;
      int_clr = '0;
      if (wr.valid && hit(wr.addr, OFS_INT_CLR))
      begin
         int_clr = wr.data[IRQ_W-1:0];
      end
   end

   iec_sticky #(
      .W (IRQ_W)
   ) u_int_stat (
      .core_clk (core_clk),
      .rst_n (rst_n),
      .set (int_set),
      .clr (int_clr),
      .flags (int_stat)
   );

   // ----------------------------------------------------------------
   // abort cause clear mask
   // ----------------------------------------------------------------
   // whole register on the abort clear read, one bit may be kept
   always_comb
   begin
      cause_clr = '0;
      if (rd_abort)
      begin
         cause_clr = '1;
         if (abort_keep_hold)
         begin
            cause_clr[POS_CAUSE_KEEP] = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_state.ready = 1'b1;

      next_state.transmit_abort_flag = evt.abort_set
         | (state.transmit_abort_flag & ~rd_abort);

      // new causes always win over the clear
      next_state.cause = abort_cause_set | (state.cause & ~cause_clr);

      next_state.flushed = evt.abort_set | (state.flushed & ~rd_abort);

      next_state.rx_done_flag = evt.rx_done_set | (state.rx_done_flag & ~rd_rxdone);

      // activity follows the bus, read or disable clears
      next_state.act_flag = evt.ctrl_active
         | (state.act_flag & ~rd_act & evt.ctrl_enabled);

      next_state.stop_seen_flag = evt.stop_set | (state.stop_seen_flag & ~rd_stop);

      // only the enable and interrupt clear registers take writes
      if (wr.valid && hit(wr.addr, OFS_INT_EN))
      begin
         next_state.int_en = wr.data[IRQ_W-1:0];
      end

      // read data is captured at the end of the address phase
      if (rd.valid)
      begin
         next_state.rdata = RST_WORD;
         case (rd.addr)
            OFS_ABORT_CLR: next_state.rdata[0] = state.transmit_abort_flag;
            OFS_RXDONE_CLR: next_state.rdata[0] = state.rx_done_flag;
            OFS_ACT_CLR: next_state.rdata[0] = state.act_flag;
            OFS_STOP_CLR: next_state.rdata[0] = state.stop_seen_flag;
            OFS_INT_STAT: next_state.rdata[IRQ_W-1:0] = int_stat;
            OFS_INT_EN: next_state.rdata[IRQ_W-1:0] = state.int_en;
            default: next_state.rdata = RST_WORD;
         endcase
      end

      // level interrupt from enabled status
      next_state.irq = |(int_stat & state.int_en);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state <= '0;
         state.cause <= RST_CAUSE;
         state.int_en <= RST_INT_EN;
         state.rdata <= RST_WORD;
         state.ready <= 1'b1;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      raw_event_status = RST_WORD;
      raw_event_status[POS_ABORT] = state.transmit_abort_flag;
      raw_event_status[POS_RXDONE] = state.rx_done_flag;
      raw_event_status[POS_ACT] = state.act_flag;
      raw_event_status[POS_STOP] = state.stop_seen_flag;
   end

   assign abort_cause_register = state.cause;
   assign tx_fifo_flushed = state.flushed;
   assign hrdata = state.rdata;
   assign hreadyout = state.ready;
   assign hresp = 1'b0; // always okay, hsize is word only
   assign irq = state.irq;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_abort_read;
      rd_abort && !evt.abort_set;
   endsequence

   sequence s_act_idle_read;
      rd_act && !evt.ctrl_active;
   endsequence

   AST_ABORT_CLR: assert property (s_abort_read |=> !raw_event_status[POS_ABORT])
      else $error("abort flag not cleared by read");

   AST_CAUSE_CLR: assert property (
      s_abort_read ##0 (abort_cause_set == '0 && !abort_keep_hold)
      |=> abort_cause_register == '0)
      else $error("abort cause not cleared by read");

   AST_FIFO_REL: assert property (s_abort_read |=> !tx_fifo_flushed)
      else $error("tx fifo not released by abort read");

   AST_CAUSE_KEEP: assert property (
      rd_abort && abort_keep_hold && abort_cause_register[POS_CAUSE_KEEP]
      |=> abort_cause_register[POS_CAUSE_KEEP])
      else $error("held cause bit lost on abort read");

   AST_RXD_CLR: assert property (
      rd_rxdone && !evt.rx_done_set |=> !raw_event_status[POS_RXDONE])
      else $error("receive done flag not cleared");

   AST_ACT_CLR: assert property (s_act_idle_read |=> !raw_event_status[POS_ACT])
      else $error("activity flag not cleared while idle");

   AST_ACT_HOLD: assert property (evt.ctrl_active |=> raw_event_status[POS_ACT])
      else $error("activity flag dropped while active");

   AST_ACT_AUTO: assert property (
      !evt.ctrl_enabled && !evt.ctrl_active |=> !raw_event_status[POS_ACT])
      else $error("activity flag not cleared when disabled");

   AST_ACT_READ: assert property (
      rd_act |=> hrdata[0] == $past(raw_event_status[POS_ACT]))
      else $error("activity read value wrong");

   AST_STOP_CLR: assert property (
      rd_stop && !evt.stop_set |=> !raw_event_status[POS_STOP])
      else $error("stop flag not cleared");

   AST_RSVD_ZERO: assert property (
      rd.valid && (rd_abort || rd_rxdone || rd_act || rd_stop)
      |=> hrdata[31:1] == '0 ##1 1'b1)
      else $error("reserved bits of clear register not zero");

   // irq follows enabled status one cycle later
   AST_IRQ_LEVEL: assert property ((|(int_stat & state.int_en)) |=> irq)
      else $error("interrupt not raised for enabled status");

   // irq stays low without an enabled status bit
   AST_IRQ_QUIET: assert property (!(|(int_stat & state.int_en)) |=> !irq)
      else $error("interrupt raised without enabled status");

   // flush entered on an abort event
   AST_FLUSH_SET: assert property (evt.abort_set |=> tx_fifo_flushed)
      else $error("tx fifo not flushed on abort event");

   // abort flag falls only by its read
   AST_ABORT_STAY: assert property (
      !rd_abort |=> !$fell(raw_event_status[POS_ABORT]))
      else $error("abort flag lost without its clear read");

   // receive done flag falls only by its read
   AST_RXD_STAY: assert property (
      !rd_rxdone |=> !$fell(raw_event_status[POS_RXDONE]))
      else $error("receive done flag lost without its clear read");

   // stop flag falls only by its read
   AST_STOP_STAY: assert property (
      !rd_stop |=> !$fell(raw_event_status[POS_STOP]))
      else $error("stop flag lost without its clear read");

endmodule : iec_regs

// ### sim/iec_ctrl_model.sv
// Purpose: behavioural controller side that drives events and bus state levels
// Assumes: tasks are called right after a rising core_clk edge
// Notes:   event pulses last exactly one cycle, state inputs are levels

`timescale 1ns/1ps

module iec_ctrl_model (
   // clock
   input wire logic core_clk,
   // event and state towards the register bank
   output iec_pkg::iec_evt_s evt,
   output logic [iec_pkg::CAUSE_W-1:0] abort_cause_set,
   output logic abort_keep_hold
);
   import iec_pkg::*;

   // -----------------------------------------------------------------
   // idle controller at time zero
   // -----------------------------------------------------------------
   initial
   begin
      evt = '0;
      abort_cause_set = '0;
      abort_keep_hold = 1'b0;
   end

   // one-cycle event pulse, cause bits ride with it
   task automatic pulse(input logic abort, input logic rx, input logic stop,
                        input logic [CAUSE_W-1:0] cause);
      evt.abort_set <= abort;
      evt.rx_done_set <= rx;
      evt.stop_set <= stop;
      abort_cause_set <= cause;
      @(posedge core_clk);
      evt.abort_set <= 1'b0;
      evt.rx_done_set <= 1'b0;
      evt.stop_set <= 1'b0;
      abort_cause_set <= '0;
   endtask : pulse

   // bus activity, enable and cause hold levels
   task automatic set_state(input logic active, input logic enabled, input logic keep);
      evt.ctrl_active <= active;
      evt.ctrl_enabled <= enabled;
      abort_keep_hold <= keep;
   endtask : set_state

endmodule : iec_ctrl_model

// ### sim/tb_top.sv
// Purpose: self-checking bench for the event clear register bank
// Assumes: one AHB-Lite master, hready looped back from the only slave
// Notes:   expectations are built from the package field positions

`timescale 1ns/1ps

module tb_top;
   import iec_pkg::*;

   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout, hresp, irq, tx_fifo_flushed;
   logic [31:0] hrdata, raw_event_status, abort_cause_register;
   iec_evt_s evt;
   logic [CAUSE_W-1:0] abort_cause_set;
   logic abort_keep_hold;
   int n_fail = 0;
   int cmp_count = 0;
   localparam logic [7:0] CLR_OFS [4] = '{OFS_ABORT_CLR, OFS_RXDONE_CLR, OFS_ACT_CLR,
                                          OFS_STOP_CLR};

   // device and controller side
   iec_regs uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt),
      .abort_cause_set(abort_cause_set), .abort_keep_hold(abort_keep_hold),
      .raw_event_status(raw_event_status), .abort_cause_register(abort_cause_register),
      .tx_fifo_flushed(tx_fifo_flushed), .irq(irq));
   iec_ctrl_model ctrl (.core_clk(core_clk), .evt(evt), .abort_cause_set(abort_cause_set),
      .abort_keep_hold(abort_keep_hold));

   // 50 ns clock
   initial
   begin
      forever #25 core_clk = ~core_clk;
   end

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] b32(input logic x);
      return {31'h0000_0000, x};
   endfunction : b32

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   // next edge with hready high, bounded
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge core_clk);
      while (hreadyout !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge core_clk);
      end
      if (n == 20)
         check("hready wait", 32'h0000_0000, 32'h0000_0001);
   endtask : wait_ready

   // one single word transfer, address phase then data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      check("hresp", b32(hresp), 32'h0000_0000);
   endtask : bus

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus(1'b0, a, 32'h0000_0000, d);
      check(name, d, exp);
   endtask : rd_chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      bus(1'b1, a, d, unused);
   endtask : wr

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      check("raw reset", raw_event_status, RST_WORD);
      check("cause reset", abort_cause_register, RST_CAUSE);
      check("flush reset", b32(tx_fifo_flushed), 32'h0000_0000);
      check("irq reset", b32(irq), 32'h0000_0000);
      for (int i = 0; i < 4; i++)
         rd_chk("clear reset", CLR_OFS[i], RST_WORD); // reset value
      rd_chk("unmapped", 8'h40, RST_WORD);
   endtask : t_reset

   task automatic t_abort(input logic keep);
      logic [31:0] cause;
      cause = 32'h0000_0201;
      ctrl.set_state(1'b0, 1'b1, keep);
      ctrl.pulse(1'b1, 1'b0, 1'b0, cause);
      tick(1);
      check("abort set", raw_event_status, 32'h0000_0001 << POS_ABORT);
      check("flush set", b32(tx_fifo_flushed), 32'h0000_0001);
      check("cause set", abort_cause_register, cause);
      rd_chk("abort read", OFS_ABORT_CLR, 32'h0000_0001); // flag in bit 0
      check("abort flag", raw_event_status, RST_WORD); // flag gone
      check("cause clear", abort_cause_register,
            keep ? (32'h0000_0001 << POS_CAUSE_KEEP) : RST_CAUSE); // cause
      check("flush free", b32(tx_fifo_flushed), 32'h0000_0000); // fifo freed
      rd_chk("abort reread", OFS_ABORT_CLR, RST_WORD); // stays clear
   endtask : t_abort

   task automatic t_rxstop();
      logic [31:0] both;
      both = (32'h0000_0001 << POS_RXDONE) | (32'h0000_0001 << POS_STOP);
      ctrl.pulse(1'b0, 1'b1, 1'b1, 32'h0000_0000);
      tick(1);
      check("rx stop set", raw_event_status, both);
      for (int i = 0; i < 4; i++)
         wr(CLR_OFS[i], 32'hFFFF_FFFF);
      check("after writes", raw_event_status, both); // writes ignored
      rd_chk("rx read", OFS_RXDONE_CLR, 32'h0000_0001); // upper bits zero
      check("rx flag", raw_event_status, 32'h0000_0001 << POS_STOP); // rx gone
      rd_chk("stop read", OFS_STOP_CLR, 32'h0000_0001); // flag in bit 0
      check("stop flag", raw_event_status, RST_WORD); // stop gone
   endtask : t_rxstop

   task automatic t_activity();
      logic [31:0] act;
      act = 32'h0000_0001 << POS_ACT;
      ctrl.set_state(1'b1, 1'b1, 1'b0);
      tick(2);
      check("act set", raw_event_status, act);
      rd_chk("act busy read", OFS_ACT_CLR, 32'h0000_0001); // flag value
      check("act held", raw_event_status, act); // still busy
      ctrl.set_state(1'b0, 1'b1, 1'b0);
      tick(2);
      check("act idle", raw_event_status, act);
      rd_chk("act idle read", OFS_ACT_CLR, 32'h0000_0001); // flag value
      check("act cleared", raw_event_status, RST_WORD); // idle clear
      rd_chk("act zero read", OFS_ACT_CLR, RST_WORD); // flag value
      ctrl.set_state(1'b1, 1'b1, 1'b0);
      tick(2);
      ctrl.set_state(1'b0, 1'b0, 1'b0);
      tick(2);
      check("act auto", raw_event_status, RST_WORD); // no read needed
   endtask : t_activity

   task automatic t_irq();
      rd_chk("status all", OFS_INT_STAT, 32'h0000_000F); // all four events latched
      wr(OFS_INT_CLR, 32'h0000_000F);
      rd_chk("status clear", OFS_INT_STAT, RST_WORD);
      ctrl.pulse(1'b0, 1'b1, 1'b0, 32'h0000_0000);
      tick(2);
      check("irq masked", b32(irq), 32'h0000_0000);
      rd_chk("status rx", OFS_INT_STAT, 32'h0000_0001 << IRQ_RXDONE);
      wr(OFS_INT_EN, 32'h0000_0001 << IRQ_RXDONE);
      rd_chk("enable", OFS_INT_EN, 32'h0000_0001 << IRQ_RXDONE);
      check("irq raised", b32(irq), 32'h0000_0001);
      wr(OFS_INT_EN, 32'h0000_0000);
      tick(2);
      check("irq off", b32(irq), 32'h0000_0000);
      wr(OFS_INT_EN, 32'h0000_0001 << IRQ_RXDONE);
      wr(OFS_INT_CLR, 32'h0000_0001 << IRQ_RXDONE);
      tick(2);
      check("irq cleared", b32(irq), 32'h0000_0000);
      rd_chk("status gone", OFS_INT_STAT, RST_WORD);
   endtask : t_irq

   // -----------------------------------------------------------------
   // verdict and run control
   // -----------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize

   // main sequence
   initial
   begin
      tick(2);
      rst_n <= 1'b1;
      tick(1);
      t_reset();
      t_abort(1'b0);
      t_abort(1'b1);
      t_rxstop();
      t_activity();
      t_irq();
      summarize();
   end

   // hang guard
   initial
   begin
      tick(3000);
      n_fail++;
      summarize();
   end

endmodule : tb_top
